// file: rtl/sensor_power_reset_output_ctrl.sv
// power configuration, reset control and output float registers of the
// image sensor, reached over the two-wire serial control pins
// assumes timing and pixel inputs come from sensor logic on mclk
`timescale 1ns/1ps
`default_nettype none
module sensor_power_reset_output_ctrl #(
  parameter int PIX_W = 10,
  parameter logic [6:0] DEV_ADDR = sensor_ctrl_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire sensor_ctrl_pkg::timing_s timing_in,
  input wire logic [PIX_W-1:0] pixel_in,
  output sensor_ctrl_pkg::power_cfg_s power_out,
  output sensor_ctrl_pkg::reset_ctl_s reset_out,
  output sensor_ctrl_pkg::timing_s timing_out,
  output logic timing_oe,
  output logic [PIX_W-1:0] pixel_out,
  output logic pixel_oe
);
  import sensor_ctrl_pkg::*;

  reg_wr_s wr;
  logic [7:0] ptr;
  logic [7:0] rd_data_q;
  power_cfg_s power_q;
  reset_ctl_s rctl_q;
  logic [7:0] float_q;
  power_cfg_s wr_pwr;
  reset_ctl_s wr_rst;
  logic pwr_hit;
  logic rst_hit;
  logic flt_hit;

  serial_ctrl_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .mclk(mclk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .rd_data(rd_data_q),
    .wr_out(wr),
    .ptr(ptr),
    .sda_oe(sda_oe)
  );

  // open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;

  assign wr_pwr = power_cfg_s'(wr.data[CTRL_W-1:0]);
  assign wr_rst = reset_ctl_s'(wr.data[CTRL_W-1:0]);
  assign pwr_hit = wr.wr && (wr.addr == ADDR_PWR);
  assign rst_hit = wr.wr && (wr.addr == ADDR_RST);
  assign flt_hit = wr.wr && (wr.addr == ADDR_FLT);

  // a full soft reset pins the power and float registers at their defaults
  // and drops writes to them until the host clears the bit again
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      power_q <= PWR_DEFAULT;
    else if (rctl_q.full_reset)
      power_q <= PWR_DEFAULT;
    else if (pwr_hit)
      power_q <= wr_pwr;
  end

  // reset bits never clear themselves
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rctl_q <= RST_DEFAULT;
    else if (rst_hit)
      rctl_q <= wr_rst;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      float_q <= FLT_DEFAULT;
    else if (rctl_q.full_reset)
      float_q <= FLT_DEFAULT;
    else if (flt_hit)
      float_q <= wr.data;
  end

  // upper bits 7..5 of power and reset, and unmapped addresses, read as zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rd_data_q <= READ_ZERO;
    else
    begin
      case (ptr)
        ADDR_PWR: rd_data_q <= 8'(power_q);
        ADDR_RST: rd_data_q <= 8'(rctl_q);
        ADDR_FLT: rd_data_q <= float_q;
        default: rd_data_q <= READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      power_out <= PWR_DEFAULT;
    else
    begin
      power_out <= power_q;
      // clamp bit means nothing while the internal clamp is selected
      power_out.software_clamp_on <=
        power_q.software_clamp_on & power_q.clamp_sw_select;
    end
  end

  // broader resets imply the narrower section resets
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      reset_out <= RST_DEFAULT;
    else
    begin
      reset_out.full_reset <= rctl_q.full_reset;
      reset_out.state_reset <=
        rctl_q.state_reset | rctl_q.full_reset;
      reset_out.sif_reset <= rctl_q.sif_reset | rctl_q.state_reset |
        rctl_q.full_reset;
      reset_out.post_adc_reset <= rctl_q.post_adc_reset |
        rctl_q.state_reset | rctl_q.full_reset;
      reset_out.adc_chain_clear <= rctl_q.adc_chain_clear |
        rctl_q.state_reset | rctl_q.full_reset;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      timing_out <= '0;
      timing_oe <= 1'b0;
    end
    else
    begin
      timing_out <= timing_in;
      timing_oe <= float_q[FLT_TIM_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pixel_out <= '0;
      pixel_oe <= 1'b0;
    end
    else
    begin
      pixel_out <= pixel_in;
      pixel_oe <= float_q[FLT_PIX_BIT];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_pwr_wr;
    pwr_hit && !rctl_q.full_reset;
  endsequence

  sequence s_rst_wr;
    rst_hit;
  endsequence

  sequence s_flt_wr;
    flt_hit && !rctl_q.full_reset;
  endsequence

  property p_standby;
    s_pwr_wr |=> ##1 power_out.standby == $past(wr_pwr.standby, 2);
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby does not follow written bit");

  property p_bias_gen;
    s_pwr_wr |=> ##1 power_out.bias_gen_enable ==
      $past(wr_pwr.bias_gen_enable, 2);
  endproperty
  a_bias_gen: assert property (p_bias_gen)
    else $error("bias generator enable does not follow write");

  property p_resistor;
    s_pwr_wr |=> ##1
      power_out.ext_resistor == $past(wr_pwr.ext_resistor, 2);
  endproperty
  a_resistor: assert property (p_resistor)
    else $error("resistor select does not follow write");

  property p_clamp;
    s_pwr_wr |=> ##1 power_out.software_clamp_on ==
      $past(wr_pwr.software_clamp_on && wr_pwr.clamp_sw_select, 2);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("clamp on without software clamp selected");

  // a clearing write in the same cycle lets reset_out drop one cycle early
  property p_full_reset;
    rctl_q.full_reset && !rst_hit |=> ##1 power_out == PWR_DEFAULT &&
      reset_out.state_reset && !timing_oe && !pixel_oe;
  endproperty
  a_full_reset: assert property (p_full_reset)
    else $error("full reset leaves state away from default");

  property p_state_reset;
    rctl_q.state_reset && !rctl_q.full_reset && !rst_hit && !pwr_hit &&
      $stable(power_q) |=> ##1
      reset_out.sif_reset && reset_out.post_adc_reset &&
      reset_out.adc_chain_clear && power_out == $past(power_out);
  endproperty
  a_state_reset: assert property (p_state_reset)
    else $error("state reset misses a section or disturbs settings");

  property p_hold;
    (rctl_q.full_reset || rctl_q.state_reset) && !rst_hit |=>
      rctl_q == $past(rctl_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("reset bit changed without a host write");

  property p_sif;
    s_rst_wr |=> ##1 reset_out.sif_reset == $past(wr_rst.sif_reset ||
      wr_rst.state_reset || wr_rst.full_reset, 2);
  endproperty
  a_sif: assert property (p_sif)
    else $error("sensor interface reset wrong after write");

  property p_post_adc;
    s_rst_wr |=> ##1 reset_out.post_adc_reset ==
      $past(wr_rst.post_adc_reset || wr_rst.state_reset ||
      wr_rst.full_reset, 2);
  endproperty
  a_post_adc: assert property (p_post_adc)
    else $error("post converter reset wrong after write");

  property p_adc_chain;
    s_rst_wr |=> ##1 reset_out.adc_chain_clear ==
      $past(wr_rst.adc_chain_clear || wr_rst.state_reset ||
      wr_rst.full_reset, 2);
  endproperty
  a_adc_chain: assert property (p_adc_chain)
    else $error("converter chain clear wrong after write");

  property p_timing_float;
    s_flt_wr |=> ##1 timing_oe == $past(wr.data[FLT_TIM_BIT], 2);
  endproperty
  a_timing_float: assert property (p_timing_float)
    else $error("timing output enable does not follow float bit");

  property p_pixel_pass;
    pixel_oe |-> pixel_out == $past(pixel_in);
  endproperty
  a_pixel_pass: assert property (p_pixel_pass)
    else $error("driven pixel data not one cycle behind input");

  property p_pixel_bit;
    s_flt_wr |=> ##1 pixel_oe == $past(wr.data[FLT_PIX_BIT], 2);
  endproperty
  a_pixel_bit: assert property (p_pixel_bit)
    else $error("pixel output enable does not follow bit 0");
endmodule
`default_nettype wire

// file: rtl/sensor_ctrl_pkg.sv
// shared constants and carriers for the sensor power, reset and output
// float register group and its two-wire serial slave
package sensor_ctrl_pkg;
  localparam logic [7:0] ADDR_PWR = 8'h0C;
  localparam logic [7:0] ADDR_RST = 8'h0E;
  localparam logic [7:0] ADDR_FLT = 8'h12;
  localparam int CTRL_W = 5;
  localparam logic [4:0] PWR_DEFAULT = 5'h00;
  localparam logic [4:0] RST_DEFAULT = 5'h00;
  localparam logic [7:0] FLT_DEFAULT = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int FLT_PIX_BIT = 0;
  localparam int FLT_TIM_BIT = 1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // arbitrary slave address
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  // bits 4..0 of the power configuration register
  typedef struct packed {
    logic bias_gen_enable;
    logic ext_resistor;
    logic clamp_sw_select;
    logic software_clamp_on;
    logic standby;
  } power_cfg_s;

  // bits 4..0 of the reset control register
  typedef struct packed {
    logic adc_chain_clear;
    logic post_adc_reset;
    logic sif_reset;
    logic state_reset;
    logic full_reset;
  } reset_ctl_s;

  typedef struct packed {
    logic line_clock;
    logic start_of_frame;
    logic frame_clock_out;
    logic sync;
    logic strobe;
  } timing_s;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ADDR = 4'h1,
    S_ACK_A = 4'h2,
    S_REG = 4'h3,
    S_ACK_REG = 4'h4,
    S_WDATA = 4'h5,
    S_ACK_W = 4'h6,
    S_RDATA = 4'h7,
    S_ACK_R = 4'h8
  } ser_state_e;
endpackage

// file: rtl/serial_ctrl_slave.sv
// two-wire serial slave: address byte, register pointer byte, then data
// bytes with pointer auto-increment; reads return rd_data at the pointer
// assumes scl and sda come from pins; sda is open drain, pulled up outside
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_slave #(
  parameter logic [6:0] DEV_ADDR = sensor_ctrl_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] rd_data,
  output sensor_ctrl_pkg::reg_wr_s wr_out,
  output logic [7:0] ptr,
  output logic sda_oe
);
  import sensor_ctrl_pkg::*;

  logic [2:0] scl_s;
  logic [2:0] sda_s;
  ser_state_e st;
  logic [3:0] cnt;
  logic [7:0] rx;
  logic [7:0] tx;
  logic rw;
  logic nack;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end
    else
    begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
    end
  end

  // stage 0 feeds only stage 1; edges look at stages 1 and 2
  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st <= S_IDLE;
      cnt <= 4'h0;
      rx <= 8'h00;
      tx <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      ptr <= 8'h00;
      sda_oe <= 1'b0;
      wr_out <= '0;
    end
    else
    begin
      wr_out.wr <= 1'b0;
      if (start)
      begin
        st <= S_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end
      else if (stop)
      begin
        st <= S_IDLE;
        sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
        cnt <= cnt + 4'h1;
        rx <= {rx[6:0], sda_s[1]};
        if (st == S_ACK_R)
        begin
          nack <= sda_s[1];
          // bump early so rd_data is settled before the next fall
          if (!sda_s[1])
            ptr <= ptr + 8'h01;
        end
      end
      else if (scl_fall)
      begin
        case (st)
          S_ADDR:
            if (cnt == BYTE_BITS)
            begin
              if (rx[7:1] == DEV_ADDR)
              begin
                st <= S_ACK_A;
                sda_oe <= 1'b1;
                rw <= rx[0];
              end
              else
                st <= S_IDLE;
            end
          S_ACK_A:
          begin
            cnt <= 4'h0;
            if (rw)
            begin
              tx <= rd_data;
              sda_oe <= ~rd_data[7];
              st <= S_RDATA;
            end
            else
            begin
              sda_oe <= 1'b0;
              st <= S_REG;
            end
          end
          S_REG:
            if (cnt == BYTE_BITS)
            begin
              st <= S_ACK_REG;
              sda_oe <= 1'b1;
              ptr <= rx;
            end
          S_ACK_REG:
          begin
            sda_oe <= 1'b0;
            cnt <= 4'h0;
            st <= S_WDATA;
          end
          S_WDATA:
            if (cnt == BYTE_BITS)
            begin
              st <= S_ACK_W;
              sda_oe <= 1'b1;
              wr_out <= '{wr: 1'b1, addr: ptr, data: rx};
            end
          S_ACK_W:
          begin
            sda_oe <= 1'b0;
            cnt <= 4'h0;
            ptr <= ptr + 8'h01;
            st <= S_WDATA;
          end
          S_RDATA:
            if (cnt == BYTE_BITS)
            begin
              sda_oe <= 1'b0;
              st <= S_ACK_R;
            end
            else
            begin
              sda_oe <= ~tx[6];
              tx <= {tx[6:0], 1'b0};
            end
          S_ACK_R:
            if (nack)
              st <= S_IDLE;
            else
            begin
              tx <= rd_data;
              sda_oe <= ~rd_data[7];
              cnt <= 4'h0;
              st <= S_RDATA;
            end
          default:
            st <= S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: test/host_i2c_model.sv
// host master on the two-wire serial control pins, bit-level tasks
// assumes the bench resolves sda with a pull-up and feeds sda_line back
`timescale 1ns/1ps
`default_nettype none
module host_i2c_model (
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  import sensor_ctrl_pkg::*;
  // mclk cycles per bus phase; raise it to act as a slow host
  int ph = 10;
  logic [6:0] dev = DEV_ADDR_DEFAULT;

  initial
  begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  task automatic gap();
    repeat (ph) @(negedge mclk);
  endtask

  // serves from idle and as a repeated start with scl low
  task automatic start_cond();
    gap();
    sda_low = 1'h0;
    gap();
    scl = 1'h1;
    gap();
    sda_low = 1'h1;
    gap();
    scl = 1'h0;
  endtask

  task automatic stop_cond();
    gap();
    sda_low = 1'h1;
    gap();
    scl = 1'h1;
    gap();
    sda_low = 1'h0;
    gap();
  endtask

  // data changes only mid low phase, never next to an scl edge
  task automatic bit_xfer(input logic b, output logic got);
    gap();
    sda_low = !b;
    gap();
    scl = 1'h1;
    gap();
    got = sda_line;
    scl = 1'h0;
  endtask

  task automatic byte_xfer(input logic [7:0] tx, output logic [7:0] rx,
                           output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(tx[i], rx[i]);
    end
    bit_xfer(1'h1, b);
    ack = !b;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic [7:0] rx;
    logic k1;
    logic k2;
    logic k3;
    start_cond();
    byte_xfer({dev, 1'h0}, rx, k1);
    byte_xfer(a, rx, k2);
    byte_xfer(d, rx, k3);
    stop_cond();
    ok = k1 & k2 & k3;
  endtask

  // single byte read ends with a host nack
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start_cond();
    byte_xfer({dev, 1'h0}, d, k);
    byte_xfer(a, d, k);
    start_cond();
    byte_xfer({dev, 1'h1}, d, k);
    byte_xfer(8'hFF, d, k);
    stop_cond();
  endtask

  // three byte read, host acks all but the last byte
  task automatic read3(input logic [7:0] a, output logic [23:0] d);
    logic [7:0] rx;
    logic k;
    start_cond();
    byte_xfer({dev, 1'h0}, rx, k);
    byte_xfer(a, rx, k);
    start_cond();
    byte_xfer({dev, 1'h1}, rx, k);
    for (int n = 0; n < 3; n++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        bit_xfer(1'h1, d[8 * (2 - n) + i]);
      end
      bit_xfer(n == 2, k);
    end
    stop_cond();
  endtask
endmodule
`default_nettype wire

// file: test/test_sensor_power_reset_output_ctrl.sv
// bench for the power, reset and output float register group
// assumes host_i2c_model drives the pins; sda pulled up in here
`timescale 1ns/1ps
`default_nettype none
module test_sensor_power_reset_output_ctrl;
  import sensor_ctrl_pkg::*;
  localparam int LIMIT = 90000;
  typedef struct {
    logic [7:0] a;
    logic [7:0] d;
    logic [4:0] pw;
    logic [4:0] rs;
    logic [1:0] oe;
  } row_s;
  // cumulative: each row expects the outputs after its write
  // upper bits always written as zero
  row_s rows [15] = '{
    '{8'h0C, 8'h01, 5'h01, 5'h00, 2'h0}, '{8'h0C, 8'h10, 5'h10, 5'h00, 2'h0},
    '{8'h0C, 8'h08, 5'h08, 5'h00, 2'h0}, '{8'h0C, 8'h02, 5'h00, 5'h00, 2'h0},
    '{8'h0C, 8'h04, 5'h04, 5'h00, 2'h0}, '{8'h0C, 8'h06, 5'h06, 5'h00, 2'h0},
    '{8'h0C, 8'h00, 5'h00, 5'h00, 2'h0}, '{8'h12, 8'h01, 5'h00, 5'h00, 2'h1},
    '{8'h12, 8'h02, 5'h00, 5'h00, 2'h2}, '{8'h12, 8'h03, 5'h00, 5'h00, 2'h3},
    '{8'h0E, 8'h04, 5'h00, 5'h04, 2'h3}, '{8'h0E, 8'h08, 5'h00, 5'h08, 2'h3},
    '{8'h0E, 8'h10, 5'h00, 5'h10, 2'h3}, '{8'h0E, 8'h02, 5'h00, 5'h1E, 2'h3},
    '{8'h0E, 8'h00, 5'h00, 5'h00, 2'h3}};
  logic mclk;
  logic rst;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  wire logic sda_line;
  timing_s timing_in;
  logic [9:0] pixel_in;
  power_cfg_s power_out;
  reset_ctl_s reset_out;
  timing_s timing_out;
  logic timing_oe;
  logic [9:0] pixel_out;
  logic pixel_oe;
  logic ok;
  logic [7:0] rd;
  logic [23:0] rd3;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;

  assign sda_line = (sda_oe ? sda_out : 1'h1) & !sda_low;

  sensor_power_reset_output_ctrl sensor_power_reset_output_ctrl_inst (
    .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .timing_in(timing_in),
    .pixel_in(pixel_in), .power_out(power_out), .reset_out(reset_out),
    .timing_out(timing_out), .timing_oe(timing_oe), .pixel_out(pixel_out),
    .pixel_oe(pixel_oe));

  host_i2c_model host_i2c_model_inst (
    .mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  task automatic results();
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_i2c_model_inst.write_reg(a, d, ok);
  endtask

  initial
  begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  always @(negedge mclk)
  begin
    pixel_in <= pixel_in + 10'h001;
    timing_in <= timing_in ^ pixel_in[4:0];
  end

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      bad_count++;
      results();
    end
  end

  initial
  begin
    rst = 1'h1;
    pixel_in = 10'h000;
    timing_in = 5'h15;
    repeat (2) @(negedge mclk);
    rst = 1'h0;
    repeat (4) @(negedge mclk);
    chk({3'h0, power_out}, 8'h00);
    chk({3'h0, reset_out}, 8'h00);
    host_i2c_model_inst.read_reg(ADDR_PWR, rd);
    chk(rd, 8'h00);
    host_i2c_model_inst.read_reg(ADDR_RST, rd);
    chk(rd, 8'h00);
    for (int i = 0; i < 15; i++)
    begin
      wr(rows[i].a, rows[i].d);
      chk({7'h00, ok}, 8'h01);
      host_i2c_model_inst.read_reg(rows[i].a, rd);
      chk(rd, rows[i].d);
      chk({3'h0, power_out}, {3'h0, rows[i].pw});
      chk({3'h0, reset_out}, {3'h0, rows[i].rs});
      chk({6'h00, timing_oe, pixel_oe}, {6'h00, rows[i].oe});
    end
    @(posedge mclk);
    #1;
    chk(pixel_out[7:0], pixel_in[7:0]);
    chk({3'h0, timing_out}, {3'h0, timing_in});
    // full soft reset while power and float registers hold user values
    wr(ADDR_PWR, 8'h11);
    wr(ADDR_RST, 8'h01);
    chk({3'h0, reset_out}, 8'h1F);
    chk({3'h0, power_out}, 8'h00);
    chk({6'h00, timing_oe, pixel_oe}, 8'h00);
    wr(ADDR_PWR, 8'h01);
    host_i2c_model_inst.read_reg(ADDR_PWR, rd);
    chk(rd, 8'h00);
    host_i2c_model_inst.read_reg(ADDR_RST, rd);
    chk(rd, 8'h01);
    wr(ADDR_RST, 8'h00); // host clears the bit itself
    chk({3'h0, reset_out}, 8'h00);
    // state reset keeps user settings
    wr(ADDR_PWR, 8'h19);
    wr(ADDR_RST, 8'h02);
    chk({3'h0, power_out}, 8'h19);
    host_i2c_model_inst.read_reg(ADDR_PWR, rd);
    chk(rd, 8'h19);
    // burst read walks the pointer across the unmapped gap
    host_i2c_model_inst.read3(ADDR_PWR, rd3);
    chk(rd3[23:16], 8'h19);
    chk(rd3[15:8], READ_ZERO);
    chk(rd3[7:0], 8'h02);
    wr(ADDR_RST, 8'h00);
    // wrong slave address and unmapped register leave standby alone
    host_i2c_model_inst.dev = DEV_ADDR_DEFAULT ^ 7'h01;
    wr(ADDR_PWR, 8'h00);
    chk({7'h00, ok}, 8'h00);
    host_i2c_model_inst.dev = DEV_ADDR_DEFAULT;
    wr(8'h20, 8'h00);
    host_i2c_model_inst.read_reg(8'h20, rd);
    chk(rd, READ_ZERO);
    chk({3'h0, power_out}, 8'h19);
    // slow host leaves standby
    host_i2c_model_inst.ph = 30;
    wr(ADDR_PWR, 8'h18);
    chk({3'h0, power_out}, 8'h18);
    results();
  end
endmodule
`default_nettype wire
